/* include/grm_pkg.sv */
// Package with constants and types for the guest/root mode control block.
package grm_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] GRM_OFS_CTRL = 8'h00;
  localparam logic [7:0] GRM_OFS_GCTRL = 8'h04;
  localparam logic [7:0] GRM_OFS_MODE = 8'h08;
  localparam logic [7:0] GRM_OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] GRM_OFS_IRQ_MASK = 8'h10;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int GRM_CTRL_GE = 0;
  localparam int GRM_CTRL_EXL = 1;
  localparam int GRM_CTRL_ERL = 2;
  localparam int GRM_CTRL_DM = 3;
  localparam int GRM_CTRL_PL_LO = 4;
  localparam int GRM_GCTRL_EXL = 0;
  localparam int GRM_GCTRL_ERL = 1;
  localparam int GRM_GCTRL_PL_LO = 2;
  localparam int GRM_MODE_LO = 0;
  localparam int GRM_MODE_GUEST = 4;
  localparam int GRM_MODE_ROOT = 5;
  localparam int GRM_MODE_CTX = 6;

  // ************************************************************
  // Reset values and event bits
  // ************************************************************
  localparam logic GRM_RST_GE = 1'h0;
  localparam logic GRM_RST_ERL = 1'h1;
  localparam logic [1:0] GRM_PL_KERNEL = 2'h0;
  localparam logic [1:0] GRM_PL_SUPER = 2'h1;
  localparam logic [1:0] GRM_PL_USER = 2'h2;
  localparam int GRM_EV_ENTER_GUEST = 0;
  localparam int GRM_EV_EXIT_GUEST = 1;
  localparam int GRM_EV_HYPERVISOR_CALL_INSTR = 2;
  localparam int GRM_EV_BAD_PL = 3;
  localparam int GRM_NEV = 4;

  typedef enum logic [3:0] {
    GRM_M_DEBUG = 4'h0,
    GRM_M_ROOT_KERNEL = 4'h1,
    GRM_M_ROOT_SUPER = 4'h2,
    GRM_M_ROOT_USER = 4'h3,
    GRM_M_GUEST_KERNEL = 4'h4,
    GRM_M_GUEST_SUPER = 4'h5,
    GRM_M_GUEST_USER = 4'h6,
    GRM_M_UNPRED = 4'h7,
    GRM_M_UNDEF = 4'h8
  } grm_mode_t;

endpackage : grm_pkg

/* verilog/grm_mode_decode.sv */
// Combinational decode of the operating mode from the root and guest control bits.
`timescale 1ns/1ps
module grm_mode_decode
  import grm_pkg::*;
(
  input wire logic guest_enable_bit,
  input wire logic root_exception_level_bit,
  input wire logic root_error_level_bit,
  input wire logic debug_active_bit,
  input wire logic [1:0] root_privilege_level_field,
  input wire logic guest_exception_level_bit,
  input wire logic guest_error_level_bit,
  input wire logic [1:0] guest_privilege_level_field,
  output grm_mode_t mode,
  output logic is_guest
);

  always_comb begin
    is_guest = guest_enable_bit && !root_exception_level_bit && !root_error_level_bit && !debug_active_bit;
    if (debug_active_bit) begin
      mode = GRM_M_DEBUG;
    end else if (root_error_level_bit || root_exception_level_bit) begin
      mode = GRM_M_ROOT_KERNEL;
    end else if (!guest_enable_bit) begin
      case (root_privilege_level_field)
        GRM_PL_KERNEL: mode = GRM_M_ROOT_KERNEL;
        GRM_PL_SUPER: mode = GRM_M_ROOT_SUPER;
        GRM_PL_USER: mode = GRM_M_ROOT_USER;
        default: mode = GRM_M_UNDEF;
      endcase
    end else if (root_privilege_level_field == 2'h3) begin
      mode = GRM_M_UNDEF;
    end else if (guest_error_level_bit || guest_exception_level_bit) begin
      mode = GRM_M_GUEST_KERNEL;
    end else begin
      case (guest_privilege_level_field)
        GRM_PL_KERNEL: mode = GRM_M_GUEST_KERNEL;
        GRM_PL_SUPER: mode = GRM_M_GUEST_SUPER;
        GRM_PL_USER: mode = GRM_M_GUEST_USER;
        default: mode = GRM_M_UNPRED;
      endcase
    end
  end

endmodule : grm_mode_decode

/* verilog/grm_apb_slave.sv */
// APB slave decode for the guest/root mode control registers.
`timescale 1ns/1ps
module grm_apb_slave
  import grm_pkg::*;
(
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] ctrl_rd,
  input wire logic [31:0] gctrl_rd,
  input wire logic [31:0] mode_rd,
  input wire logic [31:0] stat_rd,
  input wire logic [31:0] mask_rd,
  output logic wr_ctrl,
  output logic wr_gctrl,
  output logic wr_stat,
  output logic wr_mask,
  output logic [31:0] rdata,
  output logic err
);

  logic acc;

  // ************************************************************
  // Address decode
  // ************************************************************
  always_comb begin
    acc = psel && penable;
    wr_ctrl = 1'b0;
    wr_gctrl = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    rdata = 32'h0;
    err = 1'b0;
    if (paddr == GRM_OFS_CTRL) begin
      wr_ctrl = acc && pwrite;
      rdata = ctrl_rd;
    end else if (paddr == GRM_OFS_GCTRL) begin
      wr_gctrl = acc && pwrite;
      rdata = gctrl_rd;
    end else if (paddr == GRM_OFS_MODE) begin
      rdata = mode_rd;
      err = pwrite;
    end else if (paddr == GRM_OFS_IRQ_STAT) begin
      wr_stat = acc && pwrite;
      rdata = stat_rd;
    end else if (paddr == GRM_OFS_IRQ_MASK) begin
      wr_mask = acc && pwrite;
      rdata = mask_rd;
    end else begin
      err = 1'b1;
    end
  end

endmodule : grm_apb_slave

/* verilog/grm_ctrl.sv */
// Top level of the guest/root mode control block: control bits, transitions, mode outputs.
//
// Summary of operation
// - Guest mode is reported only with guest-enable set and root exception level, error level and debug all clear.
// - Root mode is reported when guest-enable is clear or any of debug, error level or exception level is set.
// - Instructions executed in root mode select the root register context.
// - An exception return in root mode with error level and debug clear jumps to the saved root PC and clears exception level.
// - An exception taken to root sets root exception or error level before state is saved; handler uses root context.
// - The hypervisor call instruction in guest mode raises a hypercall exception that is always taken in root mode.
// - An exception return in guest mode never leads to root mode, and guest code cannot alter root control bits.
// - In guest mode the guest privilege comes from guest error level, exception level and privilege field.
// - An exception taken in guest mode without exc_to_root leaves root levels untouched and records state in the guest context.
// - Reset sets root error level to one and clears guest-enable, so execution starts in root mode.
// - With debug active the device is in debug mode regardless of other bits, in root context with full access.
// - With debug clear, root error or exception level gives root-kernel, else with guest-enable clear the root privilege field decides.
`timescale 1ns/1ps
module grm_ctrl
  import grm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic exception_return_instr,
  input wire logic hypervisor_call_instr,
  input wire logic exc_take,
  input wire logic exc_is_error,
  input wire logic exc_to_root,
  input wire logic [63:0] exc_pc,
  input wire logic debug_enter,
  input wire logic debug_exit,
  output logic [63:0] ret_target,
  output logic ret_valid,
  output logic hypercall_exc,
  output logic guest_mode,
  output logic root_mode,
  output logic guest_ctx_sel,
  output logic [3:0] mode_code,
  output logic irq
);

  // ************************************************************
  // State
  // ************************************************************
  logic ge_ff, nxt_ge;
  logic rexl_ff, nxt_rexl;
  logic rerl_ff, nxt_rerl;
  logic dm_ff, nxt_dm;
  logic [1:0] rpl_ff, nxt_rpl;
  logic gexl_ff, nxt_gexl;
  logic gerl_ff, nxt_gerl;
  logic [1:0] gpl_ff, nxt_gpl;
  logic [63:0] repc_ff, nxt_repc;
  logic [63:0] gepc_ff, nxt_gepc;
  logic [63:0] tgt_ff, nxt_tgt;
  logic rv_ff, nxt_rv;
  logic hc_ff, nxt_hc;
  logic [GRM_NEV-1:0] stat_ff, nxt_stat;
  logic [GRM_NEV-1:0] mask_ff, nxt_mask;
  logic [31:0] prdata_ff, nxt_prdata;
  logic perr_ff, nxt_perr;
  logic gm_ff, nxt_gm;
  logic rm_ff, nxt_rm;
  logic [3:0] mc_ff, nxt_mc;
  logic irq_ff, nxt_irq;

  grm_mode_t mode;
  logic is_guest;
  logic wr_ctrl, wr_gctrl, wr_stat, wr_mask, dec_err;
  logic [31:0] dec_rdata, ctrl_rd, gctrl_rd, mode_rd;
  logic [GRM_NEV-1:0] ev;

  grm_mode_decode u_dec (
    .guest_enable_bit(ge_ff),
    .root_exception_level_bit(rexl_ff),
    .root_error_level_bit(rerl_ff),
    .debug_active_bit(dm_ff),
    .root_privilege_level_field(rpl_ff),
    .guest_exception_level_bit(gexl_ff),
    .guest_error_level_bit(gerl_ff),
    .guest_privilege_level_field(gpl_ff),
    .mode(mode),
    .is_guest(is_guest)
  );

  assign ctrl_rd = {26'h0, rpl_ff, dm_ff, rerl_ff, rexl_ff, ge_ff};
  assign gctrl_rd = {28'h0, gpl_ff, gerl_ff, gexl_ff};
  assign mode_rd = {25'h0, is_guest, !is_guest, is_guest, mode};

  grm_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .ctrl_rd(ctrl_rd),
    .gctrl_rd(gctrl_rd),
    .mode_rd(mode_rd),
    .stat_rd({{(32-GRM_NEV){1'b0}}, stat_ff}),
    .mask_rd({{(32-GRM_NEV){1'b0}}, mask_ff}),
    .wr_ctrl(wr_ctrl),
    .wr_gctrl(wr_gctrl),
    .wr_stat(wr_stat),
    .wr_mask(wr_mask),
    .rdata(dec_rdata),
    .err(dec_err)
  );

  // ************************************************************
  // Mode transitions
  // ************************************************************
  always_comb begin
    nxt_ge = ge_ff;
    nxt_rexl = rexl_ff;
    nxt_rerl = rerl_ff;
    nxt_dm = dm_ff;
    nxt_rpl = rpl_ff;
    nxt_gexl = gexl_ff;
    nxt_gerl = gerl_ff;
    nxt_gpl = gpl_ff;
    nxt_repc = repc_ff;
    nxt_gepc = gepc_ff;
    nxt_tgt = tgt_ff;
    nxt_rv = 1'b0;
    nxt_hc = 1'b0;
    ev = '0;
    // Software writes model root-kernel writes; guest code has no path to them.
    if (wr_ctrl && !is_guest) begin
      nxt_ge = pwdata[GRM_CTRL_GE];
      nxt_rexl = pwdata[GRM_CTRL_EXL];
      nxt_rerl = pwdata[GRM_CTRL_ERL];
      nxt_dm = pwdata[GRM_CTRL_DM];
      nxt_rpl = pwdata[GRM_CTRL_PL_LO +: 2];
    end
    if (wr_gctrl) begin
      nxt_gexl = pwdata[GRM_GCTRL_EXL];
      nxt_gerl = pwdata[GRM_GCTRL_ERL];
      nxt_gpl = pwdata[GRM_GCTRL_PL_LO +: 2];
    end
    // Pipeline events take priority over a same-cycle software write.
    if (debug_enter) begin
      nxt_dm = 1'b1;
    end else if (debug_exit) begin
      nxt_dm = 1'b0;
    end else if (hypervisor_call_instr && is_guest) begin
      nxt_hc = 1'b1;
      nxt_rexl = 1'b1;
      nxt_repc = exc_pc;
      ev[GRM_EV_HYPERVISOR_CALL_INSTR] = 1'b1;
      ev[GRM_EV_EXIT_GUEST] = 1'b1;
    end else if (exc_take && (exc_to_root || !is_guest)) begin
      // Level set before state save so the handler sees root mode.
      if (exc_is_error) begin
        nxt_rerl = 1'b1;
      end else begin
        nxt_rexl = 1'b1;
        nxt_repc = exc_pc;
      end
      ev[GRM_EV_EXIT_GUEST] = is_guest;
    end else if (exc_take) begin
      if (exc_is_error) begin
        nxt_gerl = 1'b1;
      end else begin
        nxt_gexl = 1'b1;
        nxt_gepc = exc_pc;
      end
    end else if (exception_return_instr && !dm_ff) begin
      if (is_guest) begin
        // Only guest levels move; root bits stay so guest mode holds.
        nxt_rv = 1'b1;
        if (gerl_ff) begin
          nxt_gerl = 1'b0;
        end else begin
          nxt_gexl = 1'b0;
          nxt_tgt = gepc_ff;
        end
      end else if (!rerl_ff) begin
        nxt_rv = 1'b1;
        nxt_rexl = 1'b0;
        nxt_tgt = repc_ff;
        ev[GRM_EV_ENTER_GUEST] = ge_ff && !dm_ff;
      end
    end
    ev[GRM_EV_BAD_PL] = (mode == GRM_M_UNDEF) || (mode == GRM_M_UNPRED);
  end

  // ************************************************************
  // Outputs, interrupts and bus answer
  // ************************************************************
  always_comb begin
    nxt_stat = (stat_ff & ~(wr_stat ? pwdata[GRM_NEV-1:0] : '0)) | ev;
    nxt_mask = wr_mask ? pwdata[GRM_NEV-1:0] : mask_ff;
    nxt_irq = |(nxt_stat & nxt_mask);
    nxt_gm = is_guest;
    nxt_rm = !is_guest;
    nxt_mc = mode;
    nxt_prdata = (psel && !penable && !pwrite) ? dec_rdata : prdata_ff;
    nxt_perr = psel && !penable && dec_err;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ge_ff <= GRM_RST_GE;
      rerl_ff <= GRM_RST_ERL;
      rexl_ff <= 1'b0;
      dm_ff <= 1'b0;
      rpl_ff <= GRM_PL_KERNEL;
      gexl_ff <= 1'b0;
      gerl_ff <= 1'b0;
      gpl_ff <= GRM_PL_KERNEL;
      repc_ff <= 64'h0;
      gepc_ff <= 64'h0;
      tgt_ff <= 64'h0;
      rv_ff <= 1'b0;
      hc_ff <= 1'b0;
      stat_ff <= '0;
      mask_ff <= '0;
      prdata_ff <= 32'h0;
      perr_ff <= 1'b0;
      gm_ff <= 1'b0;
      rm_ff <= 1'b1;
      mc_ff <= GRM_M_ROOT_KERNEL;
      irq_ff <= 1'b0;
    end else begin
      ge_ff <= nxt_ge;
      rerl_ff <= nxt_rerl;
      rexl_ff <= nxt_rexl;
      dm_ff <= nxt_dm;
      rpl_ff <= nxt_rpl;
      gexl_ff <= nxt_gexl;
      gerl_ff <= nxt_gerl;
      gpl_ff <= nxt_gpl;
      repc_ff <= nxt_repc;
      gepc_ff <= nxt_gepc;
      tgt_ff <= nxt_tgt;
      rv_ff <= nxt_rv;
      hc_ff <= nxt_hc;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      prdata_ff <= nxt_prdata;
      perr_ff <= nxt_perr;
      gm_ff <= nxt_gm;
      rm_ff <= nxt_rm;
      mc_ff <= nxt_mc;
      irq_ff <= nxt_irq;
    end
  end

  // The root context is selected whenever the core is not in guest mode.
  assign guest_ctx_sel = gm_ff;
  assign ret_target = tgt_ff;
  assign ret_valid = rv_ff;
  assign hypercall_exc = hc_ff;
  assign guest_mode = gm_ff;
  assign root_mode = rm_ff;
  assign mode_code = mc_ff;
  assign irq = irq_ff;
  assign prdata = prdata_ff;
  assign pslverr = perr_ff;
  assign pready = 1'b1;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_guest_def;
    @(posedge pclk) disable iff (!presetn)
      guest_mode |-> $past(ge_ff && !rexl_ff && !rerl_ff && !dm_ff);
  endproperty
  a_guest_def: assert property (p_guest_def) else $error("guest mode with root bits wrong");

  property p_root_def;
    @(posedge pclk) disable iff (!presetn)
      (!ge_ff || dm_ff || rerl_ff || rexl_ff) |=> root_mode && !guest_mode;
  endproperty
  a_root_def: assert property (p_root_def) else $error("root mode not reported");

  property p_exception_return_instr_root;
    @(posedge pclk) disable iff (!presetn)
      (exception_return_instr && !is_guest && !rerl_ff && !dm_ff && !debug_enter && !debug_exit
       && !exc_take && !hypervisor_call_instr) |=> ret_valid && !rexl_ff && ret_target == $past(repc_ff);
  endproperty
  a_exception_return_instr_root: assert property (p_exception_return_instr_root) else $error("root return wrong");

  property p_exc_root;
    @(posedge pclk) disable iff (!presetn)
      (exc_take && exc_to_root && !exc_is_error && !debug_enter && !debug_exit && !hypervisor_call_instr)
      |=> rexl_ff ##1 root_mode;
  endproperty
  a_exc_root: assert property (p_exc_root) else $error("root exception did not set level");

  property p_hypervisor_call_instr;
    @(posedge pclk) disable iff (!presetn)
      (hypervisor_call_instr && is_guest && !debug_enter && !debug_exit) |=> hypercall_exc ##1 root_mode;
  endproperty
  a_hypervisor_call_instr: assert property (p_hypervisor_call_instr) else $error("hypercall not taken in root");

  property p_guest_exception_return_instr;
    @(posedge pclk) disable iff (!presetn)
      (exception_return_instr && is_guest && !debug_enter && !exc_take && !hypervisor_call_instr)
      |=> $stable(rexl_ff) && $stable(rerl_ff) && $stable(ge_ff);
  endproperty
  a_guest_exception_return_instr: assert property (p_guest_exception_return_instr) else $error("guest return changed root bits");

  property p_guest_exc;
    @(posedge pclk) disable iff (!presetn)
      (exc_take && !exc_to_root && is_guest && !debug_enter && !debug_exit && !hypervisor_call_instr)
      |=> $stable(rexl_ff) && $stable(rerl_ff) && (gexl_ff || gerl_ff);
  endproperty
  a_guest_exc: assert property (p_guest_exc) else $error("guest exception touched root");

  property p_debug;
    @(posedge pclk) disable iff (!presetn)
      dm_ff |=> mode_code == GRM_M_DEBUG && root_mode;
  endproperty
  a_debug: assert property (p_debug) else $error("debug mode not reported");

  property p_guest_user;
    @(posedge pclk) disable iff (!presetn)
      (is_guest && !gerl_ff && !gexl_ff && gpl_ff == GRM_PL_USER && rpl_ff != 2'h3)
      |=> mode_code == GRM_M_GUEST_USER;
  endproperty
  a_guest_user: assert property (p_guest_user) else $error("guest user not decoded");

  property p_root_kernel;
    @(posedge pclk) disable iff (!presetn)
      (!dm_ff && (rerl_ff || rexl_ff)) |=> mode_code == GRM_M_ROOT_KERNEL;
  endproperty
  a_root_kernel: assert property (p_root_kernel) else $error("root kernel not decoded");

endmodule : grm_ctrl

/* test/grm_pipe_model.sv */
// Behavioural pipeline model that raises instruction and exception events.
`timescale 1ns/1ps
module grm_pipe_model (
  input wire logic pclk,
  output logic exception_return_instr,
  output logic hypervisor_call_instr,
  output logic exc_take,
  output logic exc_is_error,
  output logic exc_to_root,
  output logic [63:0] exc_pc,
  output logic debug_enter,
  output logic debug_exit
);
  logic [6:0] ev_ff = 7'h00;
  logic [63:0] pc_ff = 64'h0;
  assign exception_return_instr = ev_ff[0];
  assign hypervisor_call_instr = ev_ff[1];
  assign exc_take = ev_ff[2];
  assign exc_to_root = ev_ff[3];
  assign exc_is_error = ev_ff[4];
  assign debug_enter = ev_ff[5];
  assign debug_exit = ev_ff[6];
  assign exc_pc = pc_ff;

  // ************************************************************
  // Event issue
  // ************************************************************
  // The PC means nothing outside its event, so it is inverted afterwards to expose stale sampling.
  task automatic ev(input logic [6:0] code, input logic [63:0] pc);
    @(posedge pclk);
    ev_ff <= code;
    pc_ff <= pc;
    @(posedge pclk);
    ev_ff <= 7'h00;
    pc_ff <= ~pc;
  endtask : ev
endmodule : grm_pipe_model

/* test/tb_guest_root_mode_control.sv */
// Self-checking testbench for the guest/root mode control block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin bad_count++; $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb_guest_root_mode_control
  import grm_pkg::*;
;
  localparam int LIMIT = 4000;
  localparam logic [6:0] EV_RET = 7'h01;
  localparam logic [6:0] EV_HYP = 7'h02;
  localparam logic [6:0] EV_XGUEST = 7'h04;
  localparam logic [6:0] EV_XROOT = 7'h0C;
  localparam logic [6:0] EV_XGERR = 7'h14;
  localparam logic [6:0] EV_XRERR = 7'h1C;
  localparam logic [6:0] EV_DBG_IN = 7'h20;
  localparam logic [6:0] EV_DBG_OUT = 7'h40;
  localparam logic [63:0] PA = 64'h0000123456789ABC;
  localparam logic [63:0] PB = 64'hFEDC000011112222;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic ret_i, hyp_i, take_i, iserr_i, toroot_i, dbg_in, dbg_out;
  logic [63:0] pc_i;
  logic [63:0] ret_target;
  logic ret_valid, hypercall_exc, guest_mode, root_mode, guest_ctx_sel, irq;
  logic [3:0] mode_code;
  logic [5:0] c;
  logic [3:0] g;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;

  always #50 pclk = ~pclk;

  grm_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exception_return_instr(ret_i), .hypervisor_call_instr(hyp_i), .exc_take(take_i),
    .exc_is_error(iserr_i), .exc_to_root(toroot_i), .exc_pc(pc_i), .debug_enter(dbg_in),
    .debug_exit(dbg_out), .ret_target(ret_target), .ret_valid(ret_valid), .hypercall_exc(hypercall_exc),
    .guest_mode(guest_mode), .root_mode(root_mode), .guest_ctx_sel(guest_ctx_sel),
    .mode_code(mode_code), .irq(irq));

  grm_pipe_model pipe (.pclk(pclk), .exception_return_instr(ret_i), .hypervisor_call_instr(hyp_i),
    .exc_take(take_i), .exc_is_error(iserr_i), .exc_to_root(toroot_i), .exc_pc(pc_i),
    .debug_enter(dbg_in), .debug_exit(dbg_out));

  // ************************************************************
  // Tasks and expectations
  // ************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  always @(posedge pclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      stop_test();
    end
  end

  // The master never assumes the zero-wait answer; only the bench timeout ends a stuck wait.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic step();
    @(posedge pclk);
    #1;
  endtask : step

  function automatic logic [3:0] exp_mode(input logic [5:0] cc, input logic [3:0] gg);
    if (cc[3]) return 4'h0;
    if (cc[2] || cc[1]) return 4'h1;
    if (cc[5:4] == 2'h3) return 4'h8;
    if (!cc[0]) return 4'h1 + {2'h0, cc[5:4]};
    if (gg[1] || gg[0]) return 4'h4;
    if (gg[3:2] == 2'h3) return 4'h7;
    return 4'h4 + {2'h0, gg[3:2]};
  endfunction : exp_mode

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `CHK("mode_code", 4'h1, mode_code)
    `CHK("root_mode", 1'b1, root_mode)
    apb(1'b0, GRM_OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000004, rd)
    `CHK("pready", 1'b1, pready)
    apb(1'b0, GRM_OFS_MODE, 32'h0);
    `CHK("mode_reg", 32'h00000021, rd)
    apb(1'b1, GRM_OFS_MODE, 32'hFF);
    `CHK("mode_wr_err", 1'b1, err)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    pipe.ev(EV_RET, PB);
    #1;
    `CHK("ret_valid", 1'b0, ret_valid)
    // Every combination of root bits, with guest bits varied on the guest rows.
    for (int i = 0; i < 128; i++) begin
      c = i[5:0];
      g = {i[6], i[4], i[6] & i[5], 1'b0};
      apb(1'b1, GRM_OFS_GCTRL, {28'h0, g});
      apb(1'b1, GRM_OFS_CTRL, {26'h0, c});
      step();
      `CHK("mode_code", exp_mode(c, g), mode_code)
      `CHK("guest_mode", c[0] & ~c[1] & ~c[2] & ~c[3], guest_mode)
      `CHK("root_mode", ~(c[0] & ~c[1] & ~c[2] & ~c[3]), root_mode)
      `CHK("ctx_sel", c[0] & ~c[1] & ~c[2] & ~c[3], guest_ctx_sel)
      if (guest_mode === 1'b1) begin
        pipe.ev(EV_XROOT, 64'h0);
        step();
      end
    end
    apb(1'b1, GRM_OFS_CTRL, 32'h0);
    pipe.ev(EV_XROOT, PA);
    apb(1'b0, GRM_OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000002, rd)
    apb(1'b1, GRM_OFS_GCTRL, 32'h00000008);
    apb(1'b1, GRM_OFS_CTRL, 32'h00000003);
    apb(1'b1, GRM_OFS_IRQ_STAT, 32'h0000000F);
    apb(1'b1, GRM_OFS_IRQ_MASK, 32'h00000000);
    pipe.ev(EV_RET, 64'h0);
    #1;
    `CHK("ret_valid", 1'b1, ret_valid)
    `CHK("ret_target", PA, ret_target)
    step();
    `CHK("guest_mode", 1'b1, guest_mode)
    `CHK("mode_code", 4'h6, mode_code)
    apb(1'b0, GRM_OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000001, rd)
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, GRM_OFS_IRQ_MASK, 32'h00000001);
    step();
    `CHK("irq", 1'b1, irq)
    apb(1'b1, GRM_OFS_IRQ_STAT, 32'h00000001);
    step();
    `CHK("irq_clr", 1'b0, irq)
    // Guest code must not reach the root control bits.
    apb(1'b1, GRM_OFS_CTRL, 32'h0);
    apb(1'b0, GRM_OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000001, rd)
    pipe.ev(EV_XGUEST, PB);
    step();
    `CHK("guest_mode", 1'b1, guest_mode)
    `CHK("mode_code", 4'h4, mode_code)
    apb(1'b0, GRM_OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000001, rd)
    apb(1'b0, GRM_OFS_GCTRL, 32'h0);
    `CHK("gctrl", 32'h00000009, rd)
    pipe.ev(EV_RET, 64'h0);
    #1;
    `CHK("ret_target", PB, ret_target)
    step();
    `CHK("guest_mode", 1'b1, guest_mode)
    `CHK("mode_code", 4'h6, mode_code)
    // An error-class exception in guest mode stays in guest mode and a return clears it.
    pipe.ev(EV_XGERR, PA);
    step();
    `CHK("guest_mode", 1'b1, guest_mode)
    `CHK("mode_code", 4'h4, mode_code)
    apb(1'b0, GRM_OFS_GCTRL, 32'h0);
    `CHK("gctrl", 32'h0000000A, rd)
    pipe.ev(EV_RET, 64'h0);
    #1;
    `CHK("ret_valid", 1'b1, ret_valid)
    step();
    `CHK("guest_mode", 1'b1, guest_mode)
    `CHK("mode_code", 4'h6, mode_code)
    apb(1'b1, GRM_OFS_IRQ_MASK, 32'h00000004);
    pipe.ev(EV_HYP, PA);
    #1;
    `CHK("hypercall_exc", 1'b1, hypercall_exc)
    step();
    `CHK("root_mode", 1'b1, root_mode)
    `CHK("mode_code", 4'h1, mode_code)
    apb(1'b0, GRM_OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000003, rd)
    `CHK("irq_hyp", 1'b1, irq)
    apb(1'b1, GRM_OFS_IRQ_STAT, 32'h00000004);
    step();
    `CHK("irq_clr", 1'b0, irq)
    pipe.ev(EV_DBG_IN, 64'h0);
    step();
    `CHK("mode_code", 4'h0, mode_code)
    `CHK("root_mode", 1'b1, root_mode)
    pipe.ev(EV_RET, 64'h0);
    #1;
    `CHK("ret_valid", 1'b0, ret_valid)
    pipe.ev(EV_DBG_OUT, 64'h0);
    step();
    `CHK("mode_code", 4'h1, mode_code)
    pipe.ev(EV_XRERR, PB);
    apb(1'b0, GRM_OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000007, rd)
    pipe.ev(EV_RET, 64'h0);
    #1;
    `CHK("ret_valid", 1'b0, ret_valid)
    stop_test();
  end
endmodule : tb_guest_root_mode_control
